/* File: hdl/dpsp_pkg.sv */
// Shared constants for the dual PCM serial port
`default_nettype none
package dpsp_pkg;
    // Two pairs (receive path, send path), two cancellers on each
    localparam int PAIRS = 2;
    localparam int CHANS = 2;
    localparam int LANES = PAIRS * CHANS;
    // Sample word widths
    localparam int WORD_W = 16;
    localparam logic [4:0] LEN_COMP = 5'h08;
    localparam logic [4:0] LEN_LIN = 5'h10;
    // Bit counter of the frame-bus framing (512 bits at 4096 kbit/s)
    localparam int CNT_W = 10;
    localparam int MODE_W = 2;
    localparam int SLOTS_PER_MODE = 2;
    // Frame period and system clock
    localparam int FRAME_NS = 125000;
    localparam int SYS_CLK_NS = 5;
    localparam int FRAME_CYC = (FRAME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int TIMEOUT_FRAMES = 2;
    // Configuration synchroniser bit positions
    localparam int CFG_FBM = 0;
    localparam int CFG_LIN = 1;
    localparam int CFG_LAW = 2;
    localparam int CFG_W = 3;
endpackage
`default_nettype wire

/* File: hdl/dpsp_sync.sv */
// Three-stage synchroniser, output moves once stages two and three agree
`default_nettype none
module dpsp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Elaboration check: a zero-width chain cannot be built
    if (W < 1) begin : g_bad_w
        $error("dpsp_sync: W must be at least 1");
    end

    // Synchroniser chain, first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce) begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Agreed level: bits where stages two and three match take the new value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= (s2_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
        end
    end
endmodule
`default_nettype wire

/* File: hdl/dpsp_top.sv */
// Dual PCM serial port: link-side framing and system-side sample exchange
//
// Functional notes
// RL1 - Strobe mode: receive-path strobe A, 8 or 16 bits, frames canceller A.
// RL2 - Strobe mode: strobe B repeats every 125 us, gates canceller B.
// RL3 - Strobe mode: send-path strobe A frames canceller A independently.
// RL4 - Frame-bus mode: receive-path strobe pins select mode for both cancellers.
// RL5 - Frame-bus mode: send-path strobe pins select mode for both cancellers.
// RL6 - Receive input carries two multiplexed reference channels, A and B.
// RL7 - Send input carries two multiplexed post-echo channels, A and B.
// RL8 - Samples are companded 8-bit codes or 16-bit two's complement linear.
// RL9 - System clock is asynchronous to framing; frame events synchronised inside.
// RL10 - Law select low means mu-law, high means A-law, both cancellers.
// RL11 - Configuration input chooses strobe mode or frame-bus mode framing.
// RL12 - Output returns each channel in its input slot, under its strobe.
`default_nettype none
module dpsp_top #(
    parameter int FRAME_CYCLES = dpsp_pkg::FRAME_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic link_clk,
    input wire logic frame_bus_mode,
    input wire logic law_sel,
    input wire logic fmt_linear,
    input wire logic frame_pulse_n,
    input wire logic recv_path_strobe_a,
    input wire logic recv_path_strobe_b,
    input wire logic send_path_strobe_a,
    input wire logic send_path_strobe_b,
    input wire logic recv_in_pin,
    input wire logic send_in_pin,
    output logic send_out_pin,
    output logic recv_out_pin,
    input wire logic [15:0] send_out_word_a,
    input wire logic [15:0] send_out_word_b,
    input wire logic [15:0] recv_out_word_a,
    input wire logic [15:0] recv_out_word_b,
    output logic [15:0] recv_in_word_a,
    output logic [15:0] recv_in_word_b,
    output logic [15:0] send_in_word_a,
    output logic [15:0] send_in_word_b,
    output logic recv_in_valid_a,
    output logic recv_in_valid_b,
    output logic send_in_valid_a,
    output logic send_in_valid_b,
    output logic law_alaw,
    output logic linear_fmt,
    output logic frame_ok
);
    localparam int L = dpsp_pkg::LANES;
    localparam int W = dpsp_pkg::WORD_W;
    localparam int CW = dpsp_pkg::CNT_W;
    localparam int TO_CYC = FRAME_CYCLES * dpsp_pkg::TIMEOUT_FRAMES;
    localparam int TO_W = $clog2(TO_CYC + 1);

    // Elaboration check: the watchdog needs at least one cycle per frame
    if (FRAME_CYCLES < 1) begin : g_bad_frame
        $error("dpsp_top: FRAME_CYCLES below one");
    end

    // Lane index: bit 1 is the pair (0 receive, 1 send), bit 0 the canceller
    logic [L-1:0] strobe_pin;
    logic [1:0] data_pin;
    assign strobe_pin = {send_path_strobe_b, send_path_strobe_a,
                         recv_path_strobe_b, recv_path_strobe_a};
    assign data_pin = {send_in_pin, recv_in_pin};

    // Slot start bit within the frame-bus frame for one lane
    function automatic logic [CW-1:0] slot_start(
        input logic [dpsp_pkg::MODE_W-1:0] mode, input logic ch,
        input logic [4:0] len);
        slot_start = CW'((32'(mode) * dpsp_pkg::SLOTS_PER_MODE + 32'(ch))
                         * 32'(len));
    endfunction

    // Left-align a word of the active length so its first bit sits at bit 15
    function automatic logic [W-1:0] align_word(input logic [W-1:0] w,
                                                input logic [4:0] len);
        align_word = w << (5'(W) - len);
    endfunction

    // ---------------- Link clock domain ----------------
    logic [1:0] cfg_l;
    logic fbm_l;
    logic lin_l;
    logic [4:0] len_l;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] eff_cnt;
    logic [dpsp_pkg::MODE_W-1:0] mode_q [dpsp_pkg::PAIRS];
    logic [L-1:0] en;
    logic [L-1:0] en_prev_q;
    logic [L-1:0] tgl_q;
    logic [L-1:0] first_bit;
    logic [W-1:0] sh_in_q [L];
    logic [W-1:0] sh_out_q [L];
    logic [W-1:0] cap_q [L];
    logic [W-1:0] hold_q [L];
    logic [1:0] out_q;

    // Framing choice and format brought into the link domain
    dpsp_sync #(.W(2)) u_sync_link (
        .clk(link_clk),
        .rst(rst),
        .ce(1'b1),
        .d({fmt_linear, frame_bus_mode}),
        .q(cfg_l)
    );
    assign fbm_l = cfg_l[0];
    assign lin_l = cfg_l[1];
    assign len_l = lin_l ? dpsp_pkg::LEN_LIN : dpsp_pkg::LEN_COMP; // [RL8]

    // Frame-bus bit count, restarted by the frame pulse
    assign eff_cnt = frame_pulse_n ? cnt_q : '0;
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= eff_cnt + CW'(1);
        end
    end

    // Strobe pins read as mode selectors in frame-bus mode
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            mode_q[0] <= '0;
            mode_q[1] <= '0;
        end else if (fbm_l) begin
            mode_q[0] <= strobe_pin[1:0]; // [RL4]
            mode_q[1] <= strobe_pin[3:2]; // [RL5]
        end
    end

    // Lane enables: strobe pins or frame-bus slot windows
    always_comb begin
        for (int i = 0; i < L; i++) begin
            logic [CW-1:0] st;
            st = slot_start(mode_q[i/2], 1'(i % 2), len_l);
            if (fbm_l) begin
                en[i] = (eff_cnt >= st) && (eff_cnt < st + CW'(len_l)); // [RL11]
            end else begin
                en[i] = strobe_pin[i]; // [RL1] [RL3]
            end
            first_bit[i] = 1'(align_word(hold_q[i], len_l) >> (W - 1));
        end
    end

    // Serial capture per lane; end of enable closes the word
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            en_prev_q <= '0;
            tgl_q <= '0;
            for (int i = 0; i < L; i++) begin
                sh_in_q[i] <= '0;
                cap_q[i] <= '0;
            end
        end else begin
            en_prev_q <= en;
            for (int i = 0; i < L; i++) begin
                if (en[i]) begin
                    sh_in_q[i] <= {sh_in_q[i][W-2:0], data_pin[i/2]}; // [RL6] [RL7]
                end
                if (en_prev_q[i] && !en[i]) begin
                    cap_q[i] <= sh_in_q[i] & ((W'(1) << len_l) - W'(1)); // [RL8]
                    tgl_q[i] <= ~tgl_q[i];
                end
            end
        end
    end

    // Serial output per pair, each lane in its own slot
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            out_q <= '0;
            for (int i = 0; i < L; i++) begin
                sh_out_q[i] <= '0;
            end
        end else begin
            for (int p = 0; p < dpsp_pkg::PAIRS; p++) begin
                if (!en[2*p] && !en[2*p+1]) begin
                    out_q[p] <= 1'b0;
                end
            end
            for (int i = 0; i < L; i++) begin
                if (en[i] && !en_prev_q[i]) begin
                    out_q[i/2] <= first_bit[i]; // [RL12]
                    sh_out_q[i] <= align_word(hold_q[i], len_l) << 1;
                end else if (en[i]) begin
                    out_q[i/2] <= sh_out_q[i][W-1]; // [RL12]
                    sh_out_q[i] <= sh_out_q[i] << 1;
                end
            end
        end
    end
    assign recv_out_pin = out_q[1];
    assign send_out_pin = out_q[0];

    // ---------------- System clock domain ----------------
    logic [L-1:0] tgl_s;
    logic [L-1:0] seen_q;
    logic [L-1:0] evt;
    logic [L-1:0] valid_q;
    logic [W-1:0] word_q [L];
    logic [W-1:0] tx_word [L];
    logic [dpsp_pkg::CFG_W-1:0] cfg_s;
    logic law_q;
    logic lin_q;
    logic [TO_W-1:0] idle_q;
    logic ok_q;

    // Word-done toggles cross into the system domain
    dpsp_sync #(.W(L)) u_sync_evt (
        .clk(sys_clk),
        .rst(rst),
        .ce(clk_en),
        .d(tgl_q),
        .q(tgl_s)
    );
    // Configuration pins
    dpsp_sync #(.W(dpsp_pkg::CFG_W)) u_sync_cfg (
        .clk(sys_clk),
        .rst(rst),
        .ce(clk_en),
        .d({law_sel, fmt_linear, frame_bus_mode}),
        .q(cfg_s)
    );

    assign evt = tgl_s ^ seen_q; // [RL9]
    assign tx_word[0] = send_out_word_a;
    assign tx_word[1] = send_out_word_b;
    assign tx_word[2] = recv_out_word_a;
    assign tx_word[3] = recv_out_word_b;

    // Sample hand-over: capture the finished word, latch the reply word
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seen_q <= '0;
            valid_q <= '0;
            for (int i = 0; i < L; i++) begin
                word_q[i] <= '0;
                hold_q[i] <= '0;
            end
        end else if (clk_en) begin
            seen_q <= tgl_s;
            valid_q <= evt; // [RL9]
            for (int i = 0; i < L; i++) begin
                if (evt[i]) begin
                    word_q[i] <= cap_q[i];
                    hold_q[i] <= tx_word[i]; // [RL12]
                end
            end
        end
    end

    // Companding law and format flags for the processing side
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            law_q <= 1'b0;
            lin_q <= 1'b0;
        end else if (clk_en) begin
            law_q <= cfg_s[dpsp_pkg::CFG_LAW]; // [RL10]
            lin_q <= cfg_s[dpsp_pkg::CFG_LIN]; // [RL8]
        end
    end

    // Frame watchdog on the canceller B receive lane
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            idle_q <= '0;
            ok_q <= 1'b0;
        end else if (clk_en) begin
            if (evt[1]) begin
                idle_q <= '0;
                ok_q <= 1'b1; // [RL2]
            end else if (idle_q >= TO_W'(TO_CYC)) begin
                ok_q <= 1'b0; // [RL2]
            end else begin
                idle_q <= idle_q + TO_W'(1);
            end
        end
    end

    assign recv_in_word_a = word_q[0];
    assign recv_in_word_b = word_q[1];
    assign send_in_word_a = word_q[2];
    assign send_in_word_b = word_q[3];
    assign recv_in_valid_a = valid_q[0];
    assign recv_in_valid_b = valid_q[1];
    assign send_in_valid_a = valid_q[2];
    assign send_in_valid_b = valid_q[3];
    assign law_alaw = law_q;
    assign linear_fmt = lin_q;
    assign frame_ok = ok_q;

    // Checks per lane
    for (genvar gi = 0; gi < L; gi++) begin : g_chk
        slot_first_a: assert property (@(posedge link_clk) disable iff (rst) // [RL12]
            (en[gi] && !en_prev_q[gi]) |=> out_q[gi/2] == $past(first_bit[gi]))
            else $error("first output bit of slot wrong");
        word_done_a: assert property (@(posedge link_clk) disable iff (rst) // [RL6]
            (en_prev_q[gi] && !en[gi]) |=> tgl_q[gi] != $past(tgl_q[gi]))
            else $error("finished word not signalled");
        strobe_gate_a: assert property (@(posedge link_clk) disable iff (rst) // [RL1]
            (!fbm_l && !strobe_pin[gi]) |=> sh_in_q[gi] == $past(sh_in_q[gi]))
            else $error("lane shifted without its strobe");
        fb_start_a: assert property (@(posedge link_clk) disable iff (rst) // [RL4]
            (fbm_l && en[gi] && !en_prev_q[gi] && frame_pulse_n)
            |-> cnt_q == slot_start(mode_q[gi/2], 1'(gi % 2), len_l))
            else $error("frame-bus slot opened at wrong bit");
        comp_width_a: assert property (@(posedge link_clk) disable iff (rst) // [RL8]
            (en_prev_q[gi] && !en[gi] && !lin_l) |=> cap_q[gi][15:8] == 8'h00)
            else $error("companded word wider than eight bits");
        evt_valid_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
            (clk_en && evt[gi]) |=> valid_q[gi] && word_q[gi] == $past(cap_q[gi]))
            else $error("synchronised word not delivered");
    end

    law_follow_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL10]
        clk_en |=> law_q == $past(cfg_s[dpsp_pkg::CFG_LAW]))
        else $error("law flag does not follow pin");
    frame_lost_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL2]
        (clk_en && !evt[1] && idle_q >= TO_W'(TO_CYC)) |=> !ok_q)
        else $error("missing frames not reported");

    strobe_word_c: cover property (@(posedge link_clk) disable iff (rst)
        !fbm_l && en_prev_q[0] && !en[0]);
    fbus_word_c: cover property (@(posedge link_clk) disable iff (rst)
        fbm_l && en_prev_q[3] && !en[3]);
    frame_lost_c: cover property (@(posedge sys_clk) disable iff (rst)
        $fell(ok_q));
endmodule
`default_nettype wire

/* File: tb/dpsp_pcm_highway.sv */
// PCM highway model driving framed serial lanes toward the port
`default_nettype none
module dpsp_pcm_highway (
    input wire logic link_clk,
    output logic recv_in_pin,
    output logic send_in_pin,
    output logic recv_path_strobe_a,
    output logic recv_path_strobe_b,
    output logic send_path_strobe_a,
    output logic send_path_strobe_b,
    output logic frame_pulse_n,
    input wire logic send_out_pin,
    input wire logic recv_out_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] stb;
    logic [1:0] din;
    // Lane k is 2*pair + canceller; pair 0 receive path, pair 1 send path
    assign {send_path_strobe_b, send_path_strobe_a} = stb[3:2];
    assign {recv_path_strobe_b, recv_path_strobe_a} = stb[1:0];
    assign recv_in_pin = din[0];
    assign send_in_pin = din[1];
    // Idle highway: no strobes, no frame pulse
    initial begin
        stb = 4'h0;
        din = 2'h0;
        frame_pulse_n = 1'b1;
    end
    // Mode codes on the strobe pins, {b,a} per pair, for frame-bus framing
    task automatic set_modes(input logic [1:0] rm, input logic [1:0] sm);
        @(posedge link_clk);
        stb <= {sm, rm};
    endtask
    // One word in, one reply word read back from the output pin; start below 0 means strobe framing
    task automatic xfer(input int k, input logic [15:0] w, input int len,
                        input int start, output logic [15:0] e);
        int p;
        p = k / 2;
        e = 16'h0000;
        @(posedge link_clk);
        if (start >= 0) begin
            frame_pulse_n <= 1'b0;
            @(posedge link_clk);
            frame_pulse_n <= 1'b1;
            repeat (start - 1) @(posedge link_clk);
        end else begin
            stb[k] <= 1'b1;
        end
        din[p] <= w[len-1];
        for (int i = 1; i <= len + 1; i++) begin
            @(posedge link_clk);
            if (i >= 2)
                e = {e[14:0], (p == 0) ? send_out_pin : recv_out_pin};
            if (i < len)
                din[p] <= w[len-1-i];
            else if (i == len) begin
                if (start < 0)
                    stb[k] <= 1'b0;
                din[p] <= ~w[0]; // Released line shows the inverse
            end
        end
        repeat (2) @(posedge link_clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_dpsp_top.sv */
// Self-checking bench of the dual PCM serial port
`default_nettype none
module tb_dpsp_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FC = 1000;
    logic sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
    logic fbm = 1'b0, law_sel = 1'b0, fmt_linear = 1'b0;
    logic [15:0] rep [4] = '{16'h003C, 16'h00C3, 16'h005A, 16'h00A5};
    logic [15:0] got [4], wd [4];
    logic [3:0] vld;
    int got_n [4] = '{0, 0, 0, 0};
    int err_count = 0, n_checks = 0;
    wire rip, sip, sop, rop, ra, rb, sa, sb, fp_n, law_alaw, linear_fmt;
    wire frame_ok;
    always #2.5 sys_clk = ~sys_clk;
    always #80 link_clk = ~link_clk;
    dpsp_top #(.FRAME_CYCLES(FC)) dpsp_top_i (.sys_clk(sys_clk), .rst(rst),
        .clk_en(clk_en), .link_clk(link_clk), .frame_bus_mode(fbm),
        .law_sel(law_sel), .fmt_linear(fmt_linear), .frame_pulse_n(fp_n),
        .recv_path_strobe_a(ra), .recv_path_strobe_b(rb),
        .send_path_strobe_a(sa), .send_path_strobe_b(sb),
        .recv_in_pin(rip), .send_in_pin(sip), .send_out_pin(sop),
        .recv_out_pin(rop), .send_out_word_a(rep[0]),
        .send_out_word_b(rep[1]), .recv_out_word_a(rep[2]),
        .recv_out_word_b(rep[3]), .recv_in_word_a(wd[0]),
        .recv_in_word_b(wd[1]), .send_in_word_a(wd[2]),
        .send_in_word_b(wd[3]), .recv_in_valid_a(vld[0]),
        .recv_in_valid_b(vld[1]), .send_in_valid_a(vld[2]),
        .send_in_valid_b(vld[3]), .law_alaw(law_alaw),
        .linear_fmt(linear_fmt), .frame_ok(frame_ok));
    dpsp_pcm_highway dpsp_pcm_highway_i (.link_clk(link_clk),
        .recv_in_pin(rip), .send_in_pin(sip), .recv_path_strobe_a(ra),
        .recv_path_strobe_b(rb), .send_path_strobe_a(sa),
        .send_path_strobe_b(sb), .frame_pulse_n(fp_n),
        .send_out_pin(sop), .recv_out_pin(rop));
    // Record every word that the port hands to the system side
    always @(posedge sys_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (vld[k] === 1'b1) begin
                got[k] <= wd[k];
                got_n[k] <= got_n[k] + 1;
            end
        end
    end
    task automatic check(input logic [15:0] g, input logic [15:0] x);
        n_checks++;
        if (g !== x) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One lane transfer; exactly one new word must reach the system side
    task automatic lane_xfer(input int k, input logic [15:0] w, input int len,
                             input int start, output logic [15:0] e);
        int n0;
        n0 = got_n[k];
        dpsp_pcm_highway_i.xfer(k, w, len, start, e);
        check(16'(got_n[k] - n0), 16'h0001);
        check(got[k], w);
    endtask
    // Law and format inputs reach the port's configuration outputs
    task automatic t_config;
        for (int v = 0; v < 2; v++) begin
            @(posedge sys_clk);
            law_sel <= v[0];
            fmt_linear <= v[0];
            repeat (12) @(posedge sys_clk);
            check({15'h0000, law_alaw}, 16'(v));
            check({15'h0000, linear_fmt}, 16'(v));
        end
        // Clock enable low freezes the system-side flags
        @(posedge sys_clk);
        clk_en <= 1'b0;
        law_sel <= 1'b0;
        repeat (12) @(posedge sys_clk);
        check({15'h0000, law_alaw}, 16'h0001);
        clk_en <= 1'b1;
        repeat (12) @(posedge sys_clk);
        check({15'h0000, law_alaw}, 16'h0000);
        @(posedge sys_clk);
        fmt_linear <= 1'b0;
        repeat (12) @(posedge sys_clk);
    endtask
    // All four strobe lanes, 8-bit words, replies back in the same slots
    task automatic t_strobe;
        logic [15:0] e;
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 4; k++) begin
                lane_xfer(k, 16'(8'h81 + 8'(k * 37 + r)), 8, -1, e);
                if (r == 1)
                    check(e, rep[k]);
            end
        end
        check({15'h0000, frame_ok}, 16'h0001);
    endtask
    // Sixteen-bit linear words on receive lane A
    task automatic t_linear;
        logic [15:0] e;
        @(posedge sys_clk);
        fmt_linear <= 1'b1;
        rep[0] <= 16'h8E3C;
        repeat (400) @(posedge sys_clk);
        lane_xfer(0, 16'hB1E7, 16, -1, e);
        lane_xfer(0, 16'h4A29, 16, -1, e);
        check(e, 16'h8E3C);
        @(posedge sys_clk);
        fmt_linear <= 1'b0;
    endtask
    // Frame-bus framing: mode pins place each canceller's slot
    task automatic t_frame_bus;
        logic [15:0] e;
        @(posedge sys_clk);
        fbm <= 1'b1;
        dpsp_pcm_highway_i.set_modes(2'h1, 2'h2);
        repeat (400) @(posedge sys_clk);
        lane_xfer(1, 16'h0036, 8, 24, e);
        check(e, rep[1]);
        // Let the running count pass the send-pair slots before re-framing
        repeat (20) @(posedge link_clk);
        lane_xfer(2, 16'h00D9, 8, 32, e);
        check(e, rep[2]);
    endtask
    // Frame watchdog falls once receive lane B goes quiet
    task automatic t_watchdog;
        logic [15:0] e;
        @(posedge sys_clk);
        fbm <= 1'b0;
        dpsp_pcm_highway_i.set_modes(2'h0, 2'h0);
        repeat (400) @(posedge sys_clk);
        lane_xfer(1, 16'h0071, 8, -1, e);
        check({15'h0000, frame_ok}, 16'h0001);
        repeat (2 * FC + 20) @(posedge sys_clk);
        check({15'h0000, frame_ok}, 16'h0000);
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (8) @(posedge link_clk);
        t_config();
        t_strobe();
        t_linear();
        t_frame_bus();
        t_watchdog();
        complete_run();
    end
endmodule
`default_nettype wire
